// *** jtag_debug_defines.vh ***
`ifndef JTAG_DEBUG_DEFINES_VH
`define JTAG_DEBUG_DEFINES_VH
// =====================================================
// instruction codes (4-bit ir per tap)
`define IR_W            4
`define IR_EXTEST       4'h0
`define IR_SAMPLE       4'h1
`define IR_IDENT        4'h2
`define IR_USERCODE     4'h3
`define IR_CHIP_ADDR    4'h4
`define IR_CHIP_DATA    4'h5
`define IR_BYPASS       4'hf
`define IR_RESET_VAL    4'h2
// =====================================================
// security register fields
`define SEC_JTAG_OFF    0
`define SEC_OTP_OFF     13
`define SEC_TAG_HI      31
`define SEC_TAG_LO      22
// =====================================================
// usercode layout
`define UC_REVISION     12'h000
`define UC_UNUSED_W     10
// =====================================================
// chip access: 32-bit words, top two address bits pick a target
`define TGT_TILE        2'h0
`define TGT_SWITCH      2'h1
`define TGT_OTP         2'h2
`define BSR_W           8
`endif

// *** jtag_tap.v ***
`timescale 1ns/10ps
`include "jtag_debug_defines.vh"
// one sixteen-state tap controller with instruction register; data paths sit outside
module jtag_tap (
   // clock and reset
   input  wire             mclk_i,
   input  wire             rst_i,
   // sampled test edges and pins
   input  wire             tck_rise_i,
   input  wire             tck_fall_i,
   input  wire             tms_i,
   input  wire             tdi_i,
   input  wire             dr_tdo_i,
   // state strobes, instruction and tdo
   output wire             capture_dr_o,
   output wire             shift_dr_o,
   output wire             update_dr_o,
   output reg  [3:0]       ir_o,
   output reg              tdo_o,
   output reg              tdo_en_o
);
   localparam S_RESET = 16'h0001, S_IDLE = 16'h0002, S_SELDR = 16'h0004, S_CAPDR = 16'h0008;
   localparam S_SHDR = 16'h0010, S_EX1DR = 16'h0020, S_PDR = 16'h0040, S_EX2DR = 16'h0080;
   localparam S_UPDR = 16'h0100, S_SELIR = 16'h0200, S_CAPIR = 16'h0400, S_SHIR = 16'h0800;
   localparam S_EX1IR = 16'h1000, S_PIR = 16'h2000, S_EX2IR = 16'h4000, S_UPIR = 16'h8000;
   reg [15:0] state_reg;
   reg [15:0] state_next;
   reg [3:0]  ir_sh_reg;
   always @* begin
      case (state_reg)
         S_RESET: state_next = tms_i ? S_RESET : S_IDLE;
         S_IDLE:  state_next = tms_i ? S_SELDR : S_IDLE;
         S_SELDR: state_next = tms_i ? S_SELIR : S_CAPDR;
         S_CAPDR: state_next = tms_i ? S_EX1DR : S_SHDR;
         S_SHDR:  state_next = tms_i ? S_EX1DR : S_SHDR;
         S_EX1DR: state_next = tms_i ? S_UPDR : S_PDR;
         S_PDR:   state_next = tms_i ? S_EX2DR : S_PDR;
         S_EX2DR: state_next = tms_i ? S_UPDR : S_SHDR;
         S_UPDR:  state_next = tms_i ? S_SELDR : S_IDLE;
         S_SELIR: state_next = tms_i ? S_RESET : S_CAPIR;
         S_CAPIR: state_next = tms_i ? S_EX1IR : S_SHIR;
         S_SHIR:  state_next = tms_i ? S_EX1IR : S_SHIR;
         S_EX1IR: state_next = tms_i ? S_UPIR : S_PIR;
         S_PIR:   state_next = tms_i ? S_EX2IR : S_PIR;
         S_EX2IR: state_next = tms_i ? S_UPIR : S_SHIR;
         S_UPIR:  state_next = tms_i ? S_SELDR : S_IDLE;
         default: state_next = S_RESET;
      endcase
   end
   // strobes fire in the cycle of the rising edge that leaves the state
   assign capture_dr_o = tck_rise_i & (state_reg == S_CAPDR);
   assign shift_dr_o   = tck_rise_i & (state_reg == S_SHDR);
   assign update_dr_o  = tck_rise_i & (state_reg == S_UPDR);
   always @(posedge mclk_i) begin
      if (rst_i) begin
         state_reg <= S_RESET;
         ir_sh_reg <= 4'h0;
         ir_o      <= `IR_RESET_VAL;
         tdo_o     <= 1'b0;
         tdo_en_o  <= 1'b0;
      end else begin
         if (tck_rise_i) begin
            state_reg <= state_next;
            if (state_reg == S_CAPIR)
               ir_sh_reg <= 4'h1;
            else if (state_reg == S_SHIR)
               ir_sh_reg <= {tdi_i, ir_sh_reg[3:1]};
            if (state_reg == S_UPIR)
               ir_o <= ir_sh_reg;
            else if (state_reg == S_RESET)
               ir_o <= `IR_RESET_VAL;
         end
         // tdo moves on the falling edge only
         if (tck_fall_i) begin
            tdo_o    <= (state_reg == S_SHIR) ? ir_sh_reg[0] : dr_tdo_i;
            tdo_en_o <= (state_reg == S_SHIR) | (state_reg == S_SHDR);
         end
      end
   end
endmodule

// *** jtag_debug_chain.v ***
`timescale 1ns/10ps
`include "jtag_debug_defines.vh"
module jtag_debug_chain #(
   parameter [31:0] IDENT_CODE = 32'h1234_5679  // arbitrary value, bit 0 set
) (
   // system clock and reset
   input  wire             mclk_i,
   input  wire             srst_i,
   // jtag pins
   input  wire             tck_i,
   input  wire             tms_i,
   input  wire             tdi_i,
   input  wire             trst_n_i,
   output wire             tdo_o,
   output wire             tdo_en_o,
   // global reset and boot
   input  wire             rst_n_i,
   input  wire             pll_lock_i,
   output reg              chip_rst_o,
   output reg              boot_start_o,
   // debug sync pin
   input  wire             dbg_sync_n_i,
   output wire             dbg_sync_n_o,
   output reg              dbg_sync_oe_o,
   // tile side
   input  wire             dbg_sync_out_mode_i,
   input  wire             dbg_sync_in_mode_i,
   input  wire             breakpoint_i,
   output reg              debug_req_o,
   input  wire [31:0]      security_i,
   input  wire [`BSR_W-1:0] pin_in_i,
   output reg  [`BSR_W-1:0] pin_out_o,
   output reg              extest_o,
   // chip access port
   output reg              acc_req_o,
   output reg              acc_wr_o,
   output reg  [1:0]       acc_tgt_o,
   output reg  [29:0]      acc_addr_o,
   output reg  [31:0]      acc_wdata_o,
   input  wire [31:0]      acc_rdata_i
);
   // =====================================================
   // pin synchronisers
   reg [1:0] tck_s_reg, tms_s_reg, tdi_s_reg, trst_s_reg, rst_s_reg, dbg_s_reg, lock_s_reg;
   reg       tck_d_reg;
   always @(posedge mclk_i) begin
      tck_s_reg  <= {tck_s_reg[0], tck_i};
      tms_s_reg  <= {tms_s_reg[0], tms_i};
      tdi_s_reg  <= {tdi_s_reg[0], tdi_i};
      trst_s_reg <= {trst_s_reg[0], trst_n_i};
      rst_s_reg  <= {rst_s_reg[0], rst_n_i};
      dbg_s_reg  <= {dbg_s_reg[0], dbg_sync_n_i};
      lock_s_reg <= {lock_s_reg[0], pll_lock_i};
      tck_d_reg  <= tck_s_reg[1];
   end
   wire tck_rise = tck_s_reg[1] & ~tck_d_reg;
   wire tck_fall = ~tck_s_reg[1] & tck_d_reg;
   // whole jtag logic held while test reset is low
   wire jrst = srst_i | ~trst_s_reg[1];
   // =====================================================
   // global reset: asserts chip reset straight from the pin, boot waits on lock
   reg rst_seen_reg;
   always @* chip_rst_o = ~rst_n_i | ~rst_s_reg[1];
   always @(posedge mclk_i) begin
      if (srst_i | ~rst_s_reg[1]) begin
         boot_start_o <= 1'b0;
         rst_seen_reg <= 1'b1;
      end else begin
         boot_start_o <= 1'b0;
         if (rst_seen_reg & lock_s_reg[1]) begin
            boot_start_o <= 1'b1;
            rst_seen_reg <= 1'b0;
         end
      end
   end
   // =====================================================
   // two taps in series: tdi -> boundary tap -> chip tap -> tdo
   wire       b_cap, b_sh, b_up, b_tdo, b_en;
   wire       c_cap, c_sh, c_up, c_tdo, c_en;
   wire [3:0] b_ir, c_ir;
   reg        b_dr_tdo, c_dr_tdo;
   jtag_tap u_bscan (
      .mclk_i       (mclk_i),
      .rst_i        (jrst),
      .tck_rise_i   (tck_rise),
      .tck_fall_i   (tck_fall),
      .tms_i        (tms_s_reg[1]),
      .tdi_i        (tdi_s_reg[1]),
      .dr_tdo_i     (b_dr_tdo),
      .capture_dr_o (b_cap),
      .shift_dr_o   (b_sh),
      .update_dr_o  (b_up),
      .ir_o         (b_ir),
      .tdo_o        (b_tdo),
      .tdo_en_o     (b_en)
   );
   jtag_tap u_chip (
      .mclk_i       (mclk_i),
      .rst_i        (jrst),
      .tck_rise_i   (tck_rise),
      .tck_fall_i   (tck_fall),
      .tms_i        (tms_s_reg[1]),
      .tdi_i        (b_tdo),
      .dr_tdo_i     (c_dr_tdo),
      .capture_dr_o (c_cap),
      .shift_dr_o   (c_sh),
      .update_dr_o  (c_up),
      .ir_o         (c_ir),
      .tdo_o        (c_tdo),
      .tdo_en_o     (c_en)
   );
   assign tdo_o    = c_tdo;
   assign tdo_en_o = c_en;
   // =====================================================
   // data registers
   reg [31:0]        b_sh_reg, c_sh_reg;
   reg [`BSR_W-1:0]  bsr_reg;
   reg [31:0]        addr_reg;
   wire jtag_off = security_i[`SEC_JTAG_OFF];
   wire otp_off  = security_i[`SEC_OTP_OFF];
   wire [31:0] usercode = {security_i[`SEC_TAG_HI:`SEC_TAG_LO], {`UC_UNUSED_W{1'b0}},
                           `UC_REVISION};
   // access is refused when jtag is disabled, or when the otp is fenced off and the address targets it
   wire acc_ok = ~jtag_off & ~(otp_off & (addr_reg[31:30] == `TGT_OTP));
   always @* begin
      case (b_ir)
         `IR_EXTEST, `IR_SAMPLE: b_dr_tdo = b_sh_reg[0];
         `IR_IDENT, `IR_USERCODE: b_dr_tdo = b_sh_reg[0];
         default: b_dr_tdo = b_sh_reg[0];
      endcase
      c_dr_tdo = c_sh_reg[0];
   end
   always @(posedge mclk_i) begin
      if (jrst) begin
         b_sh_reg    <= 32'h0000_0000;
         c_sh_reg    <= 32'h0000_0000;
         bsr_reg     <= {`BSR_W{1'b0}};
         pin_out_o   <= {`BSR_W{1'b0}};
         extest_o    <= 1'b0;
         addr_reg    <= 32'h0000_0000;
         acc_req_o   <= 1'b0;
         acc_wr_o    <= 1'b0;
         acc_tgt_o   <= 2'h0;
         acc_addr_o  <= 30'h0000_0000;
         acc_wdata_o <= 32'h0000_0000;
      end else begin
         acc_req_o <= 1'b0;
         extest_o  <= (b_ir == `IR_EXTEST);
         // boundary tap: bypass is one bit, boundary register is BSR_W bits
         if (b_cap) begin
            case (b_ir)
               `IR_IDENT:    b_sh_reg <= IDENT_CODE | 32'h0000_0001;
               `IR_USERCODE: b_sh_reg <= usercode;
               `IR_EXTEST, `IR_SAMPLE: b_sh_reg <= {24'h00_0000, pin_in_i};
               default:      b_sh_reg <= 32'h0000_0000;
            endcase
         end else if (b_sh) begin
            case (b_ir)
               `IR_IDENT, `IR_USERCODE: b_sh_reg <= {tdi_s_reg[1], b_sh_reg[31:1]};
               `IR_EXTEST, `IR_SAMPLE: b_sh_reg <= {24'h00_0000, tdi_s_reg[1], b_sh_reg[7:1]};
               default:      b_sh_reg <= {31'h0000_0000, tdi_s_reg[1]};
            endcase
         end
         if (b_up & ((b_ir == `IR_EXTEST) | (b_ir == `IR_SAMPLE)))
            bsr_reg <= b_sh_reg[`BSR_W-1:0];
         // pins follow the update register only while extest is selected, so a preload holds
         if (b_ir == `IR_EXTEST)
            pin_out_o <= bsr_reg;
         // chip tap: address word then data word; read data captured on capture
         if (c_cap) begin
            c_sh_reg <= ((c_ir == `IR_CHIP_DATA) & acc_ok) ? acc_rdata_i : 32'h0000_0000;
         end else if (c_sh) begin
            if ((c_ir == `IR_CHIP_ADDR) | (c_ir == `IR_CHIP_DATA))
               c_sh_reg <= {b_tdo, c_sh_reg[31:1]};
            else
               c_sh_reg <= {31'h0000_0000, b_tdo};
         end
         if (c_up & (c_ir == `IR_CHIP_ADDR)) begin
            addr_reg   <= c_sh_reg;
            acc_tgt_o  <= c_sh_reg[31:30];
            acc_addr_o <= c_sh_reg[29:0];
            acc_wr_o   <= 1'b0;
            acc_req_o  <= ~jtag_off & ~(otp_off & (c_sh_reg[31:30] == `TGT_OTP));
         end else if (c_up & (c_ir == `IR_CHIP_DATA) & acc_ok) begin
            acc_wdata_o <= c_sh_reg;
            acc_wr_o    <= 1'b1;
            acc_req_o   <= 1'b1;
         end
      end
   end
   // =====================================================
   // debug sync pin; open drain so the output value is always low
   assign dbg_sync_n_o = 1'b0;
   always @(posedge mclk_i) begin
      if (srst_i) begin
         dbg_sync_oe_o <= 1'b0;
         debug_req_o   <= 1'b0;
      end else begin
         // released only by reset or leaving output mode
         if (~dbg_sync_out_mode_i)
            dbg_sync_oe_o <= 1'b0;
         else if (breakpoint_i)
            dbg_sync_oe_o <= 1'b1;
         debug_req_o <= dbg_sync_in_mode_i & ~dbg_s_reg[1] & ~dbg_sync_oe_o;
      end
   end
endmodule

// *** jtag_chain_monitor.sv ***
`timescale 1ns/10ps
`include "jtag_debug_defines.vh"
module jtag_chain_monitor (
   // clock, resets and inputs
   input wire        mclk_i,
   input wire        srst_i,
   input wire        trst_n_i,
   input wire        rst_n_i,
   input wire        pll_lock_i,
   input wire        breakpoint_i,
   input wire        dbg_sync_out_mode_i,
   input wire        dbg_sync_in_mode_i,
   input wire        dbg_sync_n_i,
   input wire [31:0] security_i,
   // outputs under watch
   input wire        tdo_en_o,
   input wire        extest_o,
   input wire        chip_rst_o,
   input wire        boot_start_o,
   input wire        dbg_sync_n_o,
   input wire        dbg_sync_oe_o,
   input wire        debug_req_o,
   input wire        acc_req_o,
   input wire [1:0]  acc_tgt_o
);
   // ==========================================
   // properties
   default clocking @(posedge mclk_i); endclocking
   default disable iff (srst_i);
   // long enough to pass the test reset synchroniser
   sequence s_trst_low; !trst_n_i [*5]; endsequence
   sequence s_lock_low; !pll_lock_i [*4]; endsequence
   property p_trst_hold; s_trst_low |-> !tdo_en_o && !extest_o; endproperty
   a_trst_hold: assert property (p_trst_hold) else $error("jtag active in reset");
   property p_chip_rst; !rst_n_i |-> chip_rst_o; endproperty
   a_chip_rst: assert property (p_chip_rst) else $error("chip reset late");
   property p_boot_lock; s_lock_low |-> !boot_start_o; endproperty
   a_boot_lock: assert property (p_boot_lock) else $error("boot without lock");
   property p_sync_drive;
      $rose(dbg_sync_oe_o) |-> !dbg_sync_n_o && $past(breakpoint_i) && $past(dbg_sync_out_mode_i);
   endproperty
   a_sync_drive: assert property (p_sync_drive) else $error("sync pin driven early");
   property p_sync_off; !dbg_sync_out_mode_i [*2] |-> !dbg_sync_oe_o; endproperty
   a_sync_off: assert property (p_sync_off) else $error("sync pin driven in input mode");
   property p_debug_in;
      $rose(debug_req_o) |-> $past(dbg_sync_in_mode_i) && !$past(dbg_sync_n_i);
   endproperty
   a_debug_in: assert property (p_debug_in) else $error("debug request without pin");
   property p_jtag_off; acc_req_o |-> !security_i[`SEC_JTAG_OFF]; endproperty
   a_jtag_off: assert property (p_jtag_off) else $error("access while disabled");
   property p_otp_off;
      acc_req_o && acc_tgt_o == `TGT_OTP |-> !security_i[`SEC_OTP_OFF];
   endproperty
   a_otp_off: assert property (p_otp_off) else $error("otp access while locked");
endmodule
bind jtag_debug_chain jtag_chain_monitor jtag_chain_monitor_inst (
   .mclk_i(mclk_i), .srst_i(srst_i), .trst_n_i(trst_n_i), .rst_n_i(rst_n_i),
   .pll_lock_i(pll_lock_i), .breakpoint_i(breakpoint_i), .security_i(security_i),
   .dbg_sync_out_mode_i(dbg_sync_out_mode_i), .dbg_sync_in_mode_i(dbg_sync_in_mode_i),
   .dbg_sync_n_i(dbg_sync_n_i), .tdo_en_o(tdo_en_o), .extest_o(extest_o),
   .chip_rst_o(chip_rst_o), .boot_start_o(boot_start_o), .dbg_sync_n_o(dbg_sync_n_o),
   .dbg_sync_oe_o(dbg_sync_oe_o), .debug_req_o(debug_req_o), .acc_req_o(acc_req_o),
   .acc_tgt_o(acc_tgt_o));

// *** jtag_probe.sv ***
`timescale 1ns/10ps
module jtag_probe (
   // test pins
   output reg  tck_o,
   output reg  tms_o,
   output reg  tdi_o,
   input  wire tdo_i
);
   reg o;
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b0;
   end
   // tck idles low between frames; 48 ns period
   task step(input m, input d);
      begin
         tms_o = m;
         tdi_o = d;
         #24 tck_o = 1'b1;
         o = tdo_i;
         #24 tck_o = 1'b0;
      end
   endtask
   task reset_tap;
      integer i;
      begin
         for (i = 0; i < 5; i = i + 1)
            step(1'b1, 1'b0);
         step(1'b0, 1'b0);
      end
   endtask
   // from idle to idle; lsb first, last bit leaves shift
   task scan(input ir, input integer n, input [40:0] din, output [40:0] dout);
      integer i;
      begin
         dout = 41'h0;
         step(1'b1, 1'b0);
         if (ir)
            step(1'b1, 1'b0);
         step(1'b0, 1'b0);
         step(1'b0, 1'b0);
         for (i = 0; i < n; i = i + 1) begin
            step(i == n - 1, din[i]);
            dout[i] = o;
         end
         step(1'b1, 1'b0);
         step(1'b0, 1'b0);
         // released data line must not keep a usable value
         tdi_o = ~tdi_o;
      end
   endtask
endmodule

// *** tb_jtag_debug_chain.sv ***
`timescale 1ns/10ps
module tb_jtag_debug_chain;
   localparam [31:0] ID = 32'h0a5c_3e71; // arbitrary value, bit 0 set
   reg         mclk_i = 1'b0;
   reg         srst_i = 1'b1;
   reg         trst_n = 1'b0;
   reg         rst_n = 1'b0;
   reg         lock = 1'b0;
   reg         ext_low = 1'b0;
   reg         out_m = 1'b0;
   reg         in_m = 1'b0;
   reg         bkpt = 1'b0;
   reg  [31:0] sec = 32'h0;
   reg  [31:0] rdata = 32'h0;
   reg  [7:0]  pins = 8'h0;
   reg  [40:0] q;
   reg  [1:0]  tv;
   reg         ok;
   wire        tck, tms, tdi, tdo, tdo_en, chip_rst, boot, sync_n, sync_oe, dreq, ext, areq, awr;
   wire [7:0]  pout;
   wire [1:0]  tgt;
   wire [29:0] addr;
   wire [31:0] wdata;
   // pulled up; low when either side pulls
   wire        pin = ~((sync_oe & ~sync_n) | ext_low);
   integer     failures = 0, compares = 0, nreq = 0, nboot = 0, k;
   always #2.5 mclk_i = ~mclk_i;
   always @(posedge mclk_i) begin
      nreq = nreq + (areq === 1'b1);
      nboot = nboot + (boot === 1'b1);
   end
   jtag_probe jtag_probe_inst (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));
   jtag_debug_chain #(.IDENT_CODE(ID)) jtag_debug_chain_inst (
      .mclk_i(mclk_i), .srst_i(srst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
      .trst_n_i(trst_n), .tdo_o(tdo), .tdo_en_o(tdo_en), .rst_n_i(rst_n),
      .pll_lock_i(lock), .chip_rst_o(chip_rst), .boot_start_o(boot),
      .dbg_sync_n_i(pin), .dbg_sync_n_o(sync_n), .dbg_sync_oe_o(sync_oe),
      .dbg_sync_out_mode_i(out_m), .dbg_sync_in_mode_i(in_m), .breakpoint_i(bkpt),
      .debug_req_o(dreq), .security_i(sec), .pin_in_i(pins), .pin_out_o(pout),
      .extest_o(ext), .acc_req_o(areq), .acc_wr_o(awr), .acc_tgt_o(tgt),
      .acc_addr_o(addr), .acc_wdata_o(wdata), .acc_rdata_i(rdata));
   // ==========================================
   // helpers
   task cyc(input integer n);
      repeat (n) @(posedge mclk_i);
   endtask
   task chk(input [127:0] name, input [40:0] exp, input [40:0] got);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("mismatch %0s expected %h seen %h", name, exp, got);
         end
      end
   endtask
   // chip tap sits next to tdo, so its nibble goes first
   task ir(input [7:0] v);
      jtag_probe_inst.scan(1'b1, 8, {33'h0, v}, q);
   endtask
   task dr(input integer n, input [40:0] d);
      jtag_probe_inst.scan(1'b0, n, d, q);
   endtask
   task results;
      begin
         if (failures == 0 && compares > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   initial begin
      #150000;
      failures = failures + 1;
      results;
   end
   // ==========================================
   // tests
   initial begin
      cyc(3);
      srst_i <= 1'b0;
      cyc(20);
      chk("chip_rst", 1, chip_rst);
      chk("tdo_en", 0, tdo_en);
      rst_n <= 1'b1;
      trst_n <= 1'b1;
      cyc(12);
      chk("early boot", 0, nboot);
      lock <= 1'b1;
      cyc(8);
      chk("boot", 1, nboot);
      chk("chip_rst off", 0, chip_rst);
      rst_n <= 1'b0;
      #1 chk("async rst", 1, chip_rst);
      cyc(2);
      rst_n <= 1'b1;
      cyc(6);
      chk("reboot", 2, nboot);
      jtag_probe_inst.reset_tap;
      ir(8'h2f);
      dr(33, 41'h0);
      chk("ident", {ID, 1'b0}, q[32:0]);
      for (k = 0; k < 2; k = k + 1) begin
         cyc(1);
         sec <= k ? 32'hd540_0000 : 32'h0;
         ir(8'h3f);
         dr(33, 41'h0);
         chk("usercode", {k ? 32'hd540_0000 : 32'h0, 1'b0}, q[32:0]);
      end
      for (k = 0; k < 6; k = k + 1) begin
         tv = (k < 3) ? k[1:0] : ((k == 3) ? 2'h2 : 2'h0);
         ok = (k != 3) && (k != 5);
         cyc(1);
         sec <= (k == 3 || k == 4) ? 32'h2000 : k == 5;
         rdata <= 32'h5a00_00a5 ^ k;
         nreq = 0;
         ir(8'hf4);
         dr(33, {1'b0, tv, 30'h0123_4567 ^ k[29:0]});
         chk("read req", ok, nreq);
         if (ok)
            chk("addr", {1'b0, tv, 30'h0123_4567 ^ k[29:0]}, {awr, tgt, addr});
         ir(8'hf5);
         dr(33, {1'b0, 32'hc3c3_0000 ^ k});
         chk("rdata", ok ? 32'h5a00_00a5 ^ k : 0, q[31:0]);
         chk("write req", ok ? 2 : 0, nreq);
         if (ok)
            chk("wdata", {1'b1, 32'hc3c3_0000 ^ k}, {awr, wdata});
      end
      cyc(1);
      sec <= 32'h0;
      out_m <= 1'b1;
      cyc(4);
      chk("oe idle", 0, sync_oe);
      bkpt <= 1'b1;
      cyc(1);
      bkpt <= 1'b0;
      cyc(3);
      chk("pin", 0, pin);
      out_m <= 1'b0;
      cyc(3);
      chk("oe off", 0, sync_oe);
      in_m <= 1'b1;
      ext_low <= 1'b1;
      cyc(5);
      chk("dreq", 1, dreq);
      ext_low <= 1'b0;
      cyc(5);
      chk("dreq off", 0, dreq);
      pins <= 8'h96;
      ir(8'h1f);
      dr(9, {8'h5a, 1'b0});
      chk("preload", 8'h96, q[8:1]);
      chk("no drive", 9'h000, {ext, pout});
      ir(8'h0f);
      chk("preload pins", {1'b1, 8'h5a}, {ext, pout});
      dr(9, {8'h3c, 1'b0});
      chk("sample", 8'h96, q[8:1]);
      chk("pins", {1'b1, 8'h3c}, {ext, pout});
      cyc(1);
      trst_n <= 1'b0;
      cyc(6);
      trst_n <= 1'b1;
      cyc(4);
      chk("ir reset", 9'h000, {ext, pout});
      results;
   end
endmodule
